/* File: counter_timer_map.vh */
// register addresses, field positions, reset values and timing counts for the dual counter/timer
`ifndef COUNTER_TIMER_MAP_VH
`define COUNTER_TIMER_MAP_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_CTRL_STATUS 8'h88
`define ADDR_MODE 8'h89
`define ADDR_LOW_C0 8'h8a
`define ADDR_LOW_C1 8'h8b
`define ADDR_HIGH_C0 8'h8c
`define ADDR_HIGH_C1 8'h8d
`define ADDR_PRESCALE 8'h8e

// ****************************************
// control/status fields
// ****************************************
`define CS_OVF_C1 7
`define CS_RUN_C1 6
`define CS_OVF_C0 5
`define CS_RUN_C0 4
`define CS_IRQ_FLAG_B 3
`define CS_IRQ_TYPE_B 2
`define CS_IRQ_FLAG_A 1
`define CS_IRQ_TYPE_A 0

// ****************************************
// mode fields
// ****************************************
`define MD_GATE_C1 7
`define MD_SRC_C1 6
`define MD_MODE_C1_HI 5
`define MD_MODE_C1_LO 4
`define MD_GATE_C0 3
`define MD_SRC_C0 2
`define MD_MODE_C0_HI 1
`define MD_MODE_C0_LO 0
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3

// ****************************************
// prescale fields
// ****************************************
`define PS_SEL_C2 5
`define PS_SEL_C1 4
`define PS_SEL_C0 3

// ****************************************
// reset values and timing
// ****************************************
`define RESET_BYTE 8'h00
`define PRESCALE_DIV 4'hc
`define PRESCALE_LAST 4'hb

`endif

/* File: fall_detect.v */
// sampled level and falling-edge pulse of one synchronous input pin
`timescale 1ns/10ps
`default_nettype none

module fall_detect
(
	input  wire mclk,
	input  wire nrst,
	input  wire pin,
	output reg  level,
	output wire fall
);

	reg prev;

	// one sample per clock catches pulses held two cycles
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			level <= 1'b1;
			prev  <= 1'b1;
		end
		else
		begin
			level <= pin;
			prev  <= level;
		end
	end

	assign fall = prev & ~level;

endmodule

`default_nettype wire

/* File: dual_counter_timer_block.v */
// two 16-bit counter/timers with shared control/status, mode and prescale registers
// Contract
// - timer function counts ticks of system clock divided by one or twelve.
// - counter function counts each falling edge on its count pin.
// - count pin sampled every clock so quarter-rate events are never lost.
// - each counter is 16 bits as low and high bytes, configured independently.
// - mode 0 is 13 bits: high byte plus low bits 4..0.
// - mode 0 wrap from all ones sets the overflow flag.
// - source select 0 picks prescaled clock, 1 picks count pin falling edges.
// - counter runs when run bit set and gate off or gate pin high.
// - setting run bit leaves the count untouched.
// - mode 1 uses all 16 bits, wrap sets overflow flag.
// - mode 2 low byte counts, wrap sets flag and reloads from high byte.
// - split mode low byte uses counter 0 controls and either source.
// - split high byte counts ticks, runs on counter 1 run bit, sets flag 1.
// - counter 1 in mode 3 holds; other modes restart it.
// - during split, counter 1 counts ticks only, no flag, baud overflow still out.
// - overflow flags set by hardware, cleared by software or vectoring.
// - run bits 6 and 4 enable counters 1 and 0.
// - type bits 2 and 0 choose level (0) or falling edge (1).
// - irq flags edge-set and clearable, or follow inverted pin in level mode.
// - mode register holds gate, source, mode for counter 1 high, counter 0 low.
// - prescale bits 4 and 3 select divide-by-12 at 0, undivided at 1.
`timescale 1ns/10ps
`default_nettype none
`include "counter_timer_map.vh"

module dual_counter_timer_block
(
	input  wire       mclk,
	input  wire       nrst,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	output reg  [7:0] sfr_rdata,
	input  wire       count_pin_c0,
	input  wire       count_pin_c1,
	input  wire       ext_irq_in_a_n,
	input  wire       ext_irq_in_b_n,
	input  wire       vector_ack_c0,
	input  wire       vector_ack_c1,
	input  wire       vector_ack_ext_a,
	input  wire       vector_ack_ext_b,
	output reg        overflow_flag_c0,
	output reg        overflow_flag_c1,
	output reg        ext_irq_flag_a,
	output reg        ext_irq_flag_b,
	output reg        baud_overflow_c1
);

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0] counter_mode_reg;
	reg        run_bit_c0, run_bit_c1;
	reg        ext_irq_type_a, ext_irq_type_b;
	reg        prescale_sel_c0, prescale_sel_c1, prescale_sel_c2;
	reg  [7:0] count_low_c0, count_high_c0, count_low_c1, count_high_c1;
	reg  [3:0] div_count;

	reg  [7:0] next_low_c0, next_high_c0, next_low_c1, next_high_c1;
	reg        wrap_c0, wrap_split_high, wrap_c1;
	reg  [16:0] step_c0, step_c1;

	wire [3:0] pin_level;
	wire [3:0] pin_fall;
	wire       gating_bit_c0    = counter_mode_reg[`MD_GATE_C0];
	wire       gating_bit_c1    = counter_mode_reg[`MD_GATE_C1];
	wire       source_select_c0 = counter_mode_reg[`MD_SRC_C0];
	wire       source_select_c1 = counter_mode_reg[`MD_SRC_C1];
	wire [1:0] mode_field_c0    = counter_mode_reg[`MD_MODE_C0_HI:`MD_MODE_C0_LO];
	wire [1:0] mode_field_c1    = counter_mode_reg[`MD_MODE_C1_HI:`MD_MODE_C1_LO];
	wire       split            = (mode_field_c0 == `MODE_SPLIT);
	wire       wr_cs            = sfr_wr && (sfr_addr == `ADDR_CTRL_STATUS);

	// ****************************************
	// pin sampling
	// ****************************************
	wire [3:0] pin_vec = {ext_irq_in_b_n, ext_irq_in_a_n, count_pin_c1, count_pin_c0};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_pin
			fall_detect u_fall
			(
				.mclk  (mclk),
				.nrst  (nrst),
				.pin   (pin_vec[gi]),
				.level (pin_level[gi]),
				.fall  (pin_fall[gi])
			);
		end
	endgenerate

	// ****************************************
	// prescaler
	// ****************************************
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			div_count <= 4'h0;
		else if (div_count == `PRESCALE_LAST)
			div_count <= 4'h0;
		else
			div_count <= div_count + 4'h1;
	end

	// shared divider: ticks of both counters stay in phase
	wire       tick12  = (div_count == `PRESCALE_LAST);
	wire       tick_c0 = prescale_sel_c0 ? 1'b1 : tick12;
	wire       tick_c1 = prescale_sel_c1 ? 1'b1 : tick12;

	// ****************************************
	// run control
	// ****************************************
	wire       en_c0 = run_bit_c0 & (~gating_bit_c0 | pin_level[2]);
	wire       en_c1 = run_bit_c1 & (~gating_bit_c1 | pin_level[3]);
	wire       inc_c0 = en_c0 & (source_select_c0 ? pin_fall[0] : tick_c0);
	wire       inc_c1 = en_c1 & ((source_select_c1 && !split) ? pin_fall[1] : tick_c1);
	wire       inc_split_high = run_bit_c1 & tick_c0;

	// ****************************************
	// counting
	// ****************************************
	// returns {wrap, high, low} for modes 0 to 2
	function [16:0] step;
		input [1:0] md;
		input [7:0] hi;
		input [7:0] lo;
		input       inc;
		reg   [12:0] c13;
		reg   [15:0] c16;
		begin
			c13  = {hi, lo[4:0]} + 13'h0001;
			c16  = {hi, lo} + 16'h0001;
			step = {1'b0, hi, lo};
			if (inc)
			begin
				case (md)
					`MODE_13BIT:
						// upper low bits left as they were, read as undefined
						step = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
					`MODE_16BIT:
						step = {&{hi, lo}, c16};
					`MODE_RELOAD:
						if (&lo)
							step = {1'b1, hi, hi};
						else
							step = {1'b0, hi, c16[7:0]};
					default:
						step = {1'b0, hi, lo};
				endcase
			end
		end
	endfunction

	always @*
	begin
		step_c0 = step(mode_field_c0, count_high_c0, count_low_c0, inc_c0);
		step_c1 = step(mode_field_c1, count_high_c1, count_low_c1, inc_c1);
		wrap_split_high = 1'b0;
		if (split)
		begin
			next_low_c0  = inc_c0 ? (count_low_c0 + 8'h01) : count_low_c0;
			next_high_c0 = inc_split_high ? (count_high_c0 + 8'h01) : count_high_c0;
			wrap_c0      = inc_c0 & (&count_low_c0);
			wrap_split_high = inc_split_high & (&count_high_c0);
		end
		else
		begin
			next_low_c0  = step_c0[7:0];
			next_high_c0 = step_c0[15:8];
			wrap_c0      = step_c0[16];
		end
		if (mode_field_c1 == `MODE_SPLIT)
		begin
			next_low_c1  = count_low_c1;
			next_high_c1 = count_high_c1;
			wrap_c1      = 1'b0;
		end
		else
		begin
			next_low_c1  = step_c1[7:0];
			next_high_c1 = step_c1[15:8];
			wrap_c1      = step_c1[16];
		end
	end

	// during split only the high byte of counter 0 owns flag 1
	wire       set_ovf_c1 = split ? wrap_split_high : wrap_c1;

	// software write replaces the incremented value
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_low_c0  <= `RESET_BYTE;
			count_high_c0 <= `RESET_BYTE;
			count_low_c1  <= `RESET_BYTE;
			count_high_c1 <= `RESET_BYTE;
		end
		else
		begin
			count_low_c0  <= (sfr_wr && sfr_addr == `ADDR_LOW_C0) ? sfr_wdata : next_low_c0;
			count_high_c0 <= (sfr_wr && sfr_addr == `ADDR_HIGH_C0) ? sfr_wdata : next_high_c0;
			count_low_c1  <= (sfr_wr && sfr_addr == `ADDR_LOW_C1) ? sfr_wdata : next_low_c1;
			count_high_c1 <= (sfr_wr && sfr_addr == `ADDR_HIGH_C1) ? sfr_wdata : next_high_c1;
		end
	end

	// ****************************************
	// control, mode and prescale registers
	// ****************************************
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			counter_mode_reg <= `RESET_BYTE;
			run_bit_c0       <= 1'b0;
			run_bit_c1       <= 1'b0;
			ext_irq_type_a   <= 1'b0;
			ext_irq_type_b   <= 1'b0;
			prescale_sel_c0  <= 1'b0;
			prescale_sel_c1  <= 1'b0;
			prescale_sel_c2  <= 1'b0;
		end
		else
		begin
			if (sfr_wr && sfr_addr == `ADDR_MODE)
				counter_mode_reg <= sfr_wdata;
			if (wr_cs)
			begin
				// run bits only gate counting, the count is kept
				run_bit_c0     <= sfr_wdata[`CS_RUN_C0];
				run_bit_c1     <= sfr_wdata[`CS_RUN_C1];
				ext_irq_type_a <= sfr_wdata[`CS_IRQ_TYPE_A];
				ext_irq_type_b <= sfr_wdata[`CS_IRQ_TYPE_B];
			end
			if (sfr_wr && sfr_addr == `ADDR_PRESCALE)
			begin
				prescale_sel_c0 <= sfr_wdata[`PS_SEL_C0];
				prescale_sel_c1 <= sfr_wdata[`PS_SEL_C1];
				prescale_sel_c2 <= sfr_wdata[`PS_SEL_C2];
			end
		end
	end

	// ****************************************
	// flags
	// ****************************************
	// hardware set beats any same-cycle clear
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			overflow_flag_c0 <= 1'b0;
			overflow_flag_c1 <= 1'b0;
			ext_irq_flag_a   <= 1'b0;
			ext_irq_flag_b   <= 1'b0;
			baud_overflow_c1 <= 1'b0;
		end
		else
		begin
			if (wrap_c0)
				overflow_flag_c0 <= 1'b1;
			else if (wr_cs)
				overflow_flag_c0 <= sfr_wdata[`CS_OVF_C0];
			else if (vector_ack_c0)
				overflow_flag_c0 <= 1'b0;
			if (set_ovf_c1)
				overflow_flag_c1 <= 1'b1;
			else if (wr_cs)
				overflow_flag_c1 <= sfr_wdata[`CS_OVF_C1];
			else if (vector_ack_c1)
				overflow_flag_c1 <= 1'b0;
			// level mode mirrors the pin, so writes there have no lasting effect
			if (!ext_irq_type_a)
				ext_irq_flag_a <= ~pin_level[2];
			else if (pin_fall[2])
				ext_irq_flag_a <= 1'b1;
			else if (wr_cs)
				ext_irq_flag_a <= sfr_wdata[`CS_IRQ_FLAG_A];
			else if (vector_ack_ext_a)
				ext_irq_flag_a <= 1'b0;
			if (!ext_irq_type_b)
				ext_irq_flag_b <= ~pin_level[3];
			else if (pin_fall[3])
				ext_irq_flag_b <= 1'b1;
			else if (wr_cs)
				ext_irq_flag_b <= sfr_wdata[`CS_IRQ_FLAG_B];
			else if (vector_ack_ext_b)
				ext_irq_flag_b <= 1'b0;
			baud_overflow_c1 <= wrap_c1;
		end
	end

	// ****************************************
	// read back
	// ****************************************
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			sfr_rdata <= `RESET_BYTE;
		else if (sfr_rd)
		begin
			if (sfr_addr == `ADDR_CTRL_STATUS)
				sfr_rdata <= {overflow_flag_c1, run_bit_c1, overflow_flag_c0, run_bit_c0,
					ext_irq_flag_b, ext_irq_type_b, ext_irq_flag_a, ext_irq_type_a};
			else if (sfr_addr == `ADDR_MODE)
				sfr_rdata <= counter_mode_reg;
			else if (sfr_addr == `ADDR_PRESCALE)
				sfr_rdata <= {2'h0, prescale_sel_c2, prescale_sel_c1, prescale_sel_c0, 3'h0};
			else if (sfr_addr == `ADDR_LOW_C0)
				sfr_rdata <= count_low_c0;
			else if (sfr_addr == `ADDR_HIGH_C0)
				sfr_rdata <= count_high_c0;
			else if (sfr_addr == `ADDR_LOW_C1)
				sfr_rdata <= count_low_c1;
			else if (sfr_addr == `ADDR_HIGH_C1)
				sfr_rdata <= count_high_c1;
			else
				sfr_rdata <= 8'h00;
		end
	end

endmodule

`default_nettype wire

/* File: ctr_monitor.sv */
// port-level assertions for the dual counter/timer
`timescale 1ns/10ps
`default_nettype none

module ctr_monitor
(
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       ext_irq_in_a_n,
	input wire logic       ext_irq_in_b_n,
	input wire logic       vector_ack_c0,
	input wire logic       vector_ack_c1,
	input wire logic       overflow_flag_c0,
	input wire logic       overflow_flag_c1,
	input wire logic       ext_irq_flag_a,
	input wire logic       ext_irq_flag_b
);
	// ****
	// shadows of software-owned fields
	// ****
	logic [7:0] cs;
	logic [7:0] md;
	logic [7:0] ps;
	logic [1:0] la;
	logic [1:0] lb;
	wire        wcs = sfr_wr && sfr_addr == 8'h88;

	// la/lb count settled cycles in level mode, so the pin pipeline is full
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs <= 8'h00;
			md <= 8'h00;
			ps <= 8'h00;
			la <= 2'h0;
			lb <= 2'h0;
		end
		else
		begin
			if (wcs)
				cs <= sfr_wdata;
			if (sfr_wr && sfr_addr == 8'h89)
				md <= sfr_wdata;
			if (sfr_wr && sfr_addr == 8'h8e)
				ps <= sfr_wdata;
			la <= cs[0] ? 2'h0 : la + {1'b0, la != 2'h3};
			lb <= cs[2] ? 2'h0 : lb + {1'b0, lb != 2'h3};
		end
	end

	// ****
	// assertions
	// ****
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	chk_unmapped_read: assert property (
		sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8e) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_holds: assert property (
		!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	chk_ovf0_sticky: assert property (
		overflow_flag_c0 && !vector_ack_c0 && !wcs |=> overflow_flag_c0)
		else $error("overflow flag 0 lost");
	chk_ovf1_sticky: assert property (
		overflow_flag_c1 && !vector_ack_c1 && !wcs |=> overflow_flag_c1)
		else $error("overflow flag 1 lost");
	chk_ovf_sw_set: assert property (
		wcs |=> (overflow_flag_c0 || !$past(sfr_wdata[5])) && (overflow_flag_c1 || !$past(sfr_wdata[7])))
		else $error("software flag set ignored");
	chk_ctrl_readback: assert property (
		sfr_rd && sfr_addr == 8'h88 |=> sfr_rdata == ($past(cs) & 8'h55 | $past({overflow_flag_c1, 1'b0,
		overflow_flag_c0, 1'b0, ext_irq_flag_b, 1'b0, ext_irq_flag_a, 1'b0})))
		else $error("control read mismatch");
	chk_mode_readback: assert property (
		sfr_rd && sfr_addr == 8'h89 |=> sfr_rdata == $past(md))
		else $error("mode read mismatch");
	chk_prescale_read: assert property (
		sfr_rd && sfr_addr == 8'h8e |=> sfr_rdata == ($past(ps) & 8'h38))
		else $error("prescale read mismatch");
	chk_level_a: assert property (
		la == 2'h3 |-> ext_irq_flag_a == !$past(ext_irq_in_a_n, 2))
		else $error("level flag a not following pin");
	chk_level_b: assert property (
		lb == 2'h3 |-> ext_irq_flag_b == !$past(ext_irq_in_b_n, 2))
		else $error("level flag b not following pin");
endmodule

`default_nettype wire

/* File: count_source.sv */
// model of the external count pins
`timescale 1ns/10ps
`default_nettype none

module count_source
(
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic       sel,
	input  wire logic [7:0] np,
	output wire logic       p0,
	output wire logic       p1,
	output wire logic       busy
);
	// ****
	// np falls at a quarter of the clock rate
	// ****
	logic [9:0] ph = 10'h000;

	always @(posedge mclk)
		ph <= go ? {np, 2'b00} : ph - {9'h000, busy};
	// two clocks per level; idle high like a pulled-up pin
	assign busy = ph != 10'h000;
	assign p0   = ~busy | ~ph[1] | sel;
	assign p1   = ~busy | ~ph[1] | ~sel;
endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the dual counter/timer
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	logic       wr   = 1'b0;
	logic       rd   = 1'b0;
	logic       pa   = 1'b1;
	logic       pb   = 1'b1;
	logic       go   = 1'b0;
	logic       sel  = 1'b0;
	logic [3:0] va   = 4'h0;
	logic [7:0] a    = 8'h00;
	logic [7:0] wd   = 8'h00;
	logic [7:0] np   = 8'h00;
	logic [7:0] rdata;
	logic       p0, p1, busy, f0, f1, fa, fb, bo;
	int         err_count  = 0;
	int         n_compared = 0;
	int         cyc        = 0;

	always #50 mclk = ~mclk;

	dual_counter_timer_block dut
	(
		.mclk(mclk), .nrst(nrst), .sfr_addr(a), .sfr_wdata(wd), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_rdata(rdata), .count_pin_c0(p0), .count_pin_c1(p1), .ext_irq_in_a_n(pa),
		.ext_irq_in_b_n(pb), .vector_ack_c0(va[0]), .vector_ack_c1(va[1]), .vector_ack_ext_a(va[2]),
		.vector_ack_ext_b(va[3]), .overflow_flag_c0(f0), .overflow_flag_c1(f1), .ext_irq_flag_a(fa),
		.ext_irq_flag_b(fb), .baud_overflow_c1(bo)
	);

	count_source src (.mclk(mclk), .go(go), .sel(sel), .np(np), .p0(p0), .p1(p1), .busy(busy));

	// ****
	// tasks and reference model
	// ****
	task automatic complete_run;
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrt(input logic [7:0] ad, input logic [7:0] d);
		a = ad;
		wd = d;
		wr = 1'b1;
		@(negedge mclk);
		wr = 1'b0;
		@(negedge mclk);
	endtask

	task automatic rdc(input logic [7:0] ad, output logic [7:0] v);
		a = ad;
		rd = 1'b1;
		@(negedge mclk);
		rd = 1'b0;
		v = rdata;
		@(negedge mclk);
	endtask

	// {flag, high, low} after n increments; mode 3 is the split low byte
	function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] hi, lo, input int n);
		logic f;
		logic c;
		f = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			c = 1'b0;
			if (m == 2'h0)
				{c, hi, lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'h1;
			else if (m == 2'h1)
				{c, hi, lo} = {1'b0, hi, lo} + 17'h1;
			else
				{c, lo} = {1'b0, lo} + 9'h1;
			if (c && m == 2'h2)
				lo = hi;
			f = f | c;
		end
		return {f, hi, lo};
	endfunction

	// a hang counts as a mismatch
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			complete_run;
		end
	end

	// ****
	// scenarios
	// ****
	initial
	begin
		logic [7:0]  v, vh, hi, lo, msk;
		logic [16:0] e, e1;
		logic [1:0]  m;
		logic        c, s;
		int          d, k;
		void'($urandom(32'h7eff4bbb));
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		for (int r = 8'h87; r < 8'h90; r++)
		begin
			rdc(8'(r), v);
			check(v, 0);
		end
		// every mode on both counters, either prescale
		for (int i = 0; i < 16; i++)
		begin
			c = i[0];
			m = 2'(i >> 1);
			s = i[3];
			hi = s ? 8'hff : 8'($urandom);
			lo = s ? 8'(8'hff - $urandom_range(0, 20)) : 8'($urandom) & 8'h7f;
			d = s ? $urandom_range(0, 40) : 12 * $urandom_range(1, 4) - 2;
			k = (m == 2'h3 && c) ? 0 : (s ? d + 2 : (d + 2) / 12);
			e = model(m, hi, lo, k);
			e1 = model(m, hi, lo, k - 1);
			msk = m == 2'h0 ? 8'h1f : 8'hff;
			wrt(8'h89, {2'b00, m, 2'b00, (c ? 2'b00 : m)});
			wrt(8'h8e, {3'b000, s, s, 3'b000});
			wrt(8'(8'h8a + c), lo);
			wrt(8'(8'h8c + c), hi);
			wrt(8'h88, c ? 8'h40 : 8'h10);
			repeat (d) @(negedge mclk);
			if (e[16] == e1[16])
				check(c ? f1 : f0, e1[16]);
			wrt(8'h88, 8'h00);
			rdc(8'(8'h8a + c), v);
			rdc(8'(8'h8c + c), vh);
			check({vh, v & msk}, {e[15:8], e[7:0] & msk});
		end
		// both gates on, reserved prescale bits written high
		wrt(8'h89, 8'h99);
		wrt(8'h8e, 8'hdf);
		rdc(8'h89, v);
		check(v, 8'h99);
		rdc(8'h8e, v);
		check(v, 8'h18);
		for (int g = 0; g < 4; g++)
		begin
			{pb, pa} = g[0] ? 2'b11 : 2'b00;
			wrt(8'(8'h8a + g[1]), 8'h00);
			wrt(8'h88, g[1] ? 8'h40 : 8'h10);
			repeat (6) @(negedge mclk);
			wrt(8'h88, 8'h00);
			rdc(8'(8'h8a + g[1]), v);
			check(v, g[0] ? 8 : 0);
		end
		// write lands on a cycle that also increments
		wrt(8'h88, 8'h10);
		wrt(8'h8a, 8'h5a);
		rdc(8'h8a, v);
		wrt(8'h88, 8'h00);
		check(v, 8'h5b);
		pa = 1'b1;
		for (int j = 0; j < 2; j++)
		begin
			np = 8'($urandom_range(1, 30));
			sel = j[0];
			wrt(8'h89, j ? 8'h50 : 8'h05);
			wrt(8'(8'h8a + j), 8'h00);
			wrt(8'h88, j ? 8'h40 : 8'h10);
			go = 1'b1;
			@(negedge mclk);
			go = 1'b0;
			while (busy)
				@(negedge mclk);
			repeat (3) @(negedge mclk);
			wrt(8'h88, 8'h00);
			rdc(8'(8'h8a + j), v);
			check(v, np);
		end
		// split: high byte of counter 0 runs on the counter 1 run bit
		wrt(8'h89, 8'h03);
		wrt(8'h8a, 8'h00);
		wrt(8'h8c, 8'hfe);
		wrt(8'h88, 8'h40);
		repeat (5) @(negedge mclk);
		check(f1, 1);
		wrt(8'h88, 8'h00);
		rdc(8'h8c, vh);
		rdc(8'h8a, v);
		check({vh, v}, 16'h0500);
		wrt(8'h8c, 8'h00);
		wrt(8'h8b, 8'h1f);
		wrt(8'h8d, 8'hff);
		wrt(8'h8e, 8'h18);
		wrt(8'h88, 8'h40);
		check(bo, 1);
		repeat (2) @(negedge mclk);
		check(f1, 0);
		wrt(8'h88, 8'h05);
		rdc(8'h88, v);
		check(v, 8'h05);
		for (int j = 0; j < 4; j++)
		begin
			if (j < 2)
				wrt(8'h88, j ? 8'h85 : 8'h25);
			else
				{pb, pa} = j == 2 ? 2'b10 : 2'b01;
			repeat (3) @(negedge mclk);
			check({fb, fa, f1, f0} >> j & 4'h1, 1);
			{pb, pa} = 2'b11;
			va = 4'(4'h1 << j);
			@(negedge mclk);
			va = 4'h0;
			@(negedge mclk);
			check({fb, fa, f1, f0} >> j & 4'h1, 0);
		end
		wrt(8'h88, 8'h00);
		repeat (40)
		begin
			{pb, pa} = 2'($urandom);
			@(negedge mclk);
		end
		complete_run;
	end
endmodule

bind dual_counter_timer_block ctr_monitor mon (.*);

`default_nettype wire
